// >>> src/cbm_pkg.sv
// Purpose: shared constants and types of the charge broadcast master
// Assumes: system clock 250 MHz, link clock about 33 MHz
// Notes:   addresses are 8-bit bus forms with the write bit at bit 0
package cbm_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned T_SYS_NS = 4;
  localparam int unsigned T_SEC_NS = 1000000000;
  localparam int unsigned SEC_CYCLES = T_SEC_NS / T_SYS_NS;
  localparam int unsigned T_LINK_NS = 30;
  // quarter of a 100 kHz bus clock period, rounded up
  localparam int unsigned T_QTR_NS = 2500;
  localparam int unsigned QTR_CYCLES = (T_QTR_NS + T_LINK_NS - 1) / T_LINK_NS;
  // quarters of both lines high before the bus counts as idle
  localparam logic [3:0] IDLE_QTRS = 4'h8;
  localparam logic [7:0] CHG_PERIOD_S = 8'h0a;
  localparam logic [7:0] ALARM_PERIOD_S = 8'h0a;

  // ---------------------------------------------------------------
  // addresses, command codes, check byte
  // ---------------------------------------------------------------
  localparam logic [7:0] CHG_ADDR_SMB = 8'h12;
  localparam logic [7:0] HOST_ADDR = 8'h14;
  localparam logic [7:0] CMD_CURR = 8'h14;
  localparam logic [7:0] CMD_VOLT = 8'h15;
  localparam logic [7:0] CMD_ALARM = 8'h16;
  localparam logic [7:0] PEC_POLY = 8'h07;
  localparam logic [7:0] PEC_INIT = 8'h00;
  localparam logic [7:0] WR_MASK = 8'hfe;
  localparam logic [2:0] LAST_DATA = 3'h3;
  localparam logic [2:0] PEC_SLOT = 3'h4;
  localparam logic [3:0] ACK_BIT = 4'h8;

  // ---------------------------------------------------------------
  // reset values and frame kinds
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] K_VOLT = 2'h0;
  localparam logic [1:0] K_CURR = 2'h1;
  localparam logic [1:0] K_ALARM = 2'h2;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef logic [3:0][7:0] cbm_frame_t;
  typedef enum logic [1:0] {S_IDLE = 2'b01, S_WAIT = 2'b10} cbm_sstate_e;
  typedef enum logic [4:0] {
    L_IDLE = 5'b00001,
    L_CHECK = 5'b00010,
    L_START = 5'b00100,
    L_BIT = 5'b01000,
    L_STOP = 5'b10000
  } cbm_lstate_e;

endpackage

// >>> src/cbm_link_if.sv
// Purpose: carrier between the scheduler and the bus engine
// Assumes: frame and pec_en stand still while a request is open
// Notes:   toggles mark request and completion across clock domains
`timescale 1ns/1ps
`default_nettype none
interface cbm_link_if;
  import cbm_pkg::*;
  logic req_tgl;
  cbm_frame_t frame;
  logic pec_en;
  logic done_tgl;
  logic lost;
  logic nack;
  modport sys (output req_tgl, frame, pec_en, input done_tgl, lost, nack);
  modport link (input req_tgl, frame, pec_en, output done_tgl, lost, nack);
endinterface
`default_nettype wire

// >>> src/cbm_link_engine.sv
// Purpose: bit engine on the link clock, writes one frame per request
// Assumes: open-drain pins, lines read back through two flops
// Notes:   check byte is built bit by bit as the frame goes out
`timescale 1ns/1ps
`default_nettype none
module cbm_link_engine
  import cbm_pkg::*;
#(
  parameter int unsigned P_QTR_CYCLES = QTR_CYCLES
)
(
  // clock and reset
  input wire logic i_clk_link,
  input wire logic i_rst,
  // frame carrier
  cbm_link_if.link lnk,
  // bus lines
  input wire logic i_bus_clock_line,
  input wire logic i_bus_data_line,
  output logic o_scl_oe,
  output logic o_sda_oe
);

  // ---------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------
  logic rst1, rst2, rq1, rq2, rq3, scl1, scl2, sda1, sda2;
  always_ff @(posedge i_clk_link)
  begin
    rst1 <= i_rst;
    rst2 <= rst1;
    rq1 <= lnk.req_tgl;
    rq2 <= rq1;
    rq3 <= rq2;
    scl1 <= i_bus_clock_line;
    scl2 <= scl1;
    sda1 <= i_bus_data_line;
    sda2 <= sda1;
  end

  // crc-8 step for one bit
  function automatic logic [7:0] crc_bit(input logic [7:0] c, input logic b);
    crc_bit = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? PEC_POLY : RST_BYTE);
  endfunction

  // ---------------------------------------------------------------
  // engine state
  // ---------------------------------------------------------------
  cbm_lstate_e state, next_state;
  logic [7:0] qcnt, next_qcnt, sh, next_sh, crc, next_crc;
  logic [1:0] ph, next_ph;
  logic [3:0] bitn, next_bitn, idle, next_idle;
  logic [2:0] bytn, next_bytn;
  logic scl_oe, next_scl_oe, sda_oe, next_sda_oe;
  logic done, next_done, lost, next_lost, nack, next_nack;
  logic adv, tx;

  // next values: quarter-phase sequencing of start, bits and stop
  always_comb
  begin
    next_state = state;
    next_qcnt = (qcnt == 8'(P_QTR_CYCLES - 1)) ? RST_BYTE : qcnt + 8'h01;
    next_sh = sh;
    next_crc = crc;
    next_ph = ph;
    next_bitn = bitn;
    next_idle = idle;
    next_bytn = bytn;
    next_scl_oe = scl_oe;
    next_sda_oe = sda_oe;
    next_done = done;
    next_lost = lost;
    next_nack = nack;
    adv = (qcnt == 8'(P_QTR_CYCLES - 1));
    tx = (bitn == ACK_BIT) ? 1'b1 : sh[7];
    case (state)
      L_IDLE:
      begin
        next_qcnt = RST_BYTE;
        next_scl_oe = 1'b0;
        next_sda_oe = 1'b0;
        if (rq2 != rq3)
        begin
          next_sh = lnk.frame[0];
          next_bytn = 3'h0;
          next_bitn = 4'h0;
          next_crc = PEC_INIT;
          next_lost = 1'b0;
          next_nack = 1'b0;
          next_idle = 4'h0;
          next_state = L_CHECK;
        end
      end
      L_CHECK:
        if (adv)
        begin
          // both lines high long enough before a start
          if (!scl2 || !sda2)
            next_idle = 4'h0; // RULE15
          else if (idle == IDLE_QTRS - 4'h1)
          begin
            next_state = L_START;
            next_ph = 2'h0;
          end
          else
            next_idle = idle + 4'h1;
        end
      L_START:
        if (adv)
        begin
          if (ph == 2'h0)
          begin
            next_sda_oe = 1'b1;
            next_ph = 2'h1;
          end
          else
          begin
            next_scl_oe = 1'b1;
            next_ph = 2'h0;
            next_state = L_BIT;
          end
        end
      L_BIT:
        if (adv)
        begin
          case (ph)
            2'h0:
            begin
              next_sda_oe = !tx;
              next_ph = 2'h1;
            end
            2'h1:
            begin
              next_scl_oe = 1'b0;
              next_ph = 2'h2;
            end
            2'h2:
              if (scl2)
              begin
                next_ph = 2'h3;
                if (bitn == ACK_BIT)
                  next_nack = sda2;
                else if (tx && !sda2)
                begin
                  // lost arbitration: let go and give up
                  next_lost = 1'b1; // RULE15
                  next_sda_oe = 1'b0;
                  next_state = L_IDLE;
                  next_done = !done;
                end
                else
                  next_crc = crc_bit(crc, tx);
              end
            default:
            begin
              next_scl_oe = 1'b1;
              next_ph = 2'h0;
              if (bitn != ACK_BIT)
              begin
                next_bitn = bitn + 4'h1;
                next_sh = {sh[6:0], 1'b0};
              end
              else if (nack || bytn == PEC_SLOT || (bytn == LAST_DATA && !lnk.pec_en))
                next_state = L_STOP; // RULE12
              else
              begin
                // address, code, low byte, high byte, then check byte
                next_bitn = 4'h0;
                next_bytn = bytn + 3'h1;
                next_sh = (bytn == LAST_DATA) ? crc : lnk.frame[bytn[1:0] + 2'h1]; // RULE11
              end
            end
          endcase
        end
      L_STOP:
        if (adv)
        begin
          next_ph = ph + 2'h1;
          case (ph)
            2'h0: next_sda_oe = 1'b1;
            2'h1: next_scl_oe = 1'b0;
            2'h2: next_sda_oe = 1'b0;
            default:
            begin
              next_done = !done;
              next_state = L_IDLE;
            end
          endcase
        end
      default: next_state = L_IDLE;
    endcase
  end

  // registers
  always_ff @(posedge i_clk_link)
  begin
    if (rst2)
    begin
      state <= L_IDLE;
      qcnt <= RST_BYTE;
      sh <= RST_BYTE;
      crc <= PEC_INIT;
      ph <= 2'h0;
      bitn <= 4'h0;
      idle <= 4'h0;
      bytn <= 3'h0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      done <= 1'b0;
      lost <= 1'b0;
      nack <= 1'b0;
    end
    else
    begin
      state <= next_state;
      qcnt <= next_qcnt;
      sh <= next_sh;
      crc <= next_crc;
      ph <= next_ph;
      bitn <= next_bitn;
      idle <= next_idle;
      bytn <= next_bytn;
      scl_oe <= next_scl_oe;
      sda_oe <= next_sda_oe;
      done <= next_done;
      lost <= next_lost;
      nack <= next_nack;
    end
  end

  assign o_scl_oe = scl_oe;
  assign o_sda_oe = sda_oe;
  assign lnk.done_tgl = done;
  assign lnk.lost = lost;
  assign lnk.nack = nack;

endmodule // cbm_link_engine
`default_nettype wire

// >>> src/cbm_charge_broadcast_master.sv
// Purpose: schedules setpoint and alarm broadcasts as bus master
// Assumes: control inputs come from logic on i_clk_sys
// Notes:   bus engine runs on i_clk_link; toggles cross the domains
//
// Notes on behaviour
// [RULE1] host check byte appended to host broadcasts when host check is enabled
// [RULE2] charger check byte appended to charger broadcasts when charger check enabled
// [RULE3] broadcast enable low means no broadcasts at all
// [RULE4] bus mode: voltage and current written to charger 0x12 every period
// [RULE5] any alarm flag set: alarm word to host 0x14 every 10 s
// [RULE6] alarm broadcasts stop once all six flags clear
// [RULE7] i2c mode: charger address and period from stored settings
// [RULE8] i2c mode: voltage and current target registers from stored settings
// [RULE9] i2c mode: each value goes out as one whole two-byte write
// [RULE10] charger registers hold only the 16-bit value, reserved bits unaffected
// [RULE11] frame: address, code, low byte, high byte, optional check byte
// [RULE12] both check enables low: no check byte ever sent
// [RULE13] i2c mode never sends a check byte
// [RULE14] bus mode: current to code 0x14, voltage to code 0x15
// [RULE15] wait for idle bus; on lost arbitration abandon till next interval
`timescale 1ns/1ps
`default_nettype none
module cbm_charge_broadcast_master
  import cbm_pkg::*;
#(
  parameter int unsigned P_SEC_CYCLES = SEC_CYCLES,
  parameter int unsigned P_QTR_CYCLES = QTR_CYCLES
)
(
  // clocks and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_clk_link,
  // enables and mode
  input wire logic i_broadcast_enable,
  input wire logic i_host_pec_enable,
  input wire logic i_charger_pec_enable,
  input wire logic i_i2c_mode,
  // stored settings for i2c mode
  input wire logic [7:0] i_cfg_charger_addr,
  input wire logic [7:0] i_cfg_voltage_reg,
  input wire logic [7:0] i_cfg_current_reg,
  input wire logic [7:0] i_cfg_pacing_s,
  // values to broadcast
  input wire logic [15:0] i_charge_voltage,
  input wire logic [15:0] i_charge_current,
  input wire logic [15:0] i_alarm_word,
  // alarm flags
  input wire logic i_overcharge_alarm_flag,
  input wire logic i_terminate_charge_alarm_flag,
  input wire logic i_overtemp_alarm_flag,
  input wire logic i_terminate_discharge_alarm_flag,
  input wire logic i_remaining_capacity_alarm_flag,
  input wire logic i_remaining_time_alarm_flag,
  // bus pins
  input wire logic i_bus_clock_line,
  input wire logic i_bus_data_line,
  output logic o_bus_clock_line_out,
  output logic o_bus_clock_line_oe,
  output logic o_bus_data_line_out,
  output logic o_bus_data_line_oe,
  // status
  output logic o_busy,
  output logic o_last_lost,
  output logic o_last_nack,
  output logic o_alarm_active
);

  // ---------------------------------------------------------------
  // bus engine
  // ---------------------------------------------------------------
  cbm_link_if lnk ();
  logic pin_low;
  cbm_link_engine #(.P_QTR_CYCLES(P_QTR_CYCLES)) u_engine (
    .i_clk_link(i_clk_link),
    .i_rst(i_rst),
    .lnk(lnk),
    .i_bus_clock_line(i_bus_clock_line),
    .i_bus_data_line(i_bus_data_line),
    .o_scl_oe(o_bus_clock_line_oe),
    .o_sda_oe(o_bus_data_line_oe)
  );

  // open drain: the driven level is always low
  always_ff @(posedge i_clk_sys)
  begin
    pin_low <= 1'b0;
  end
  assign o_bus_clock_line_out = pin_low;
  assign o_bus_data_line_out = pin_low;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  cbm_sstate_e state, next_state;
  logic [27:0] sec_cnt, next_sec_cnt;
  logic [7:0] chg_sec, next_chg_sec, alm_sec, next_alm_sec, period;
  logic pend_v, next_pend_v, pend_i, next_pend_i, pend_a, next_pend_a;
  logic alm_run, next_alm_run, req, next_req, pec, next_pec;
  logic cur_i2c, next_cur_i2c, busy, next_busy, lost, next_lost, nack, next_nack;
  logic [1:0] kind, next_kind;
  cbm_frame_t frame, next_frame;
  logic d1, d2, d3, sec_tick, alarm_any, done_edge;

  // completion toggle from the link side
  always_ff @(posedge i_clk_sys)
  begin
    d1 <= lnk.done_tgl;
    d2 <= d1;
    d3 <= d2;
  end

  assign done_edge = d2 ^ d3;
  assign alarm_any = i_overcharge_alarm_flag | i_terminate_charge_alarm_flag
    | i_overtemp_alarm_flag | i_terminate_discharge_alarm_flag
    | i_remaining_capacity_alarm_flag | i_remaining_time_alarm_flag;
  assign sec_tick = (sec_cnt == 28'(P_SEC_CYCLES - 1));
  // a zero pacing would never expire sensibly, so it acts as one second
  assign period = i_i2c_mode ? ((i_cfg_pacing_s == RST_BYTE) ? 8'h01 : i_cfg_pacing_s)
    : CHG_PERIOD_S; // RULE7

  // next values: timers, pending broadcasts and launch
  always_comb
  begin
    next_state = state;
    next_sec_cnt = sec_tick ? 28'h0 : sec_cnt + 28'h1;
    next_chg_sec = chg_sec;
    next_alm_sec = alm_sec;
    next_pend_v = pend_v;
    next_pend_i = pend_i;
    next_pend_a = pend_a;
    next_alm_run = alm_run;
    next_req = req;
    next_pec = pec;
    next_cur_i2c = cur_i2c;
    next_busy = busy;
    next_lost = lost;
    next_nack = nack;
    next_kind = kind;
    next_frame = frame;
    case (state)
      S_IDLE:
        if (i_broadcast_enable && (pend_a || pend_v || pend_i))
        begin
          next_state = S_WAIT;
          next_req = !req;
          next_busy = 1'b1;
          next_cur_i2c = i_i2c_mode;
          if (pend_a)
          begin
            next_kind = K_ALARM;
            next_pend_a = 1'b0;
            next_frame = {i_alarm_word[15:8], i_alarm_word[7:0], CMD_ALARM,
              HOST_ADDR & WR_MASK}; // RULE5
            next_pec = i_host_pec_enable && !i_i2c_mode; // RULE1
          end
          else
          begin
            next_kind = pend_v ? K_VOLT : K_CURR;
            next_pend_v = 1'b0;
            next_pend_i = !pend_v ? 1'b0 : pend_i;
            next_frame[0] = (i_i2c_mode ? i_cfg_charger_addr : CHG_ADDR_SMB) & WR_MASK; // RULE4
            if (pend_v)
            begin
              next_frame[1] = i_i2c_mode ? i_cfg_voltage_reg : CMD_VOLT; // RULE8
              next_frame[3:2] = i_charge_voltage; // RULE9
            end
            else
            begin
              next_frame[1] = i_i2c_mode ? i_cfg_current_reg : CMD_CURR; // RULE14
              next_frame[3:2] = i_charge_current; // RULE9
            end
            next_pec = i_charger_pec_enable && !i_i2c_mode; // RULE2 RULE13
          end
        end
      S_WAIT:
        if (done_edge)
        begin
          // a lost frame is not requeued; the next interval sends fresh data
          next_lost = lnk.lost; // RULE15
          next_nack = lnk.nack;
          next_busy = 1'b0;
          next_state = S_IDLE;
        end
      default: next_state = S_IDLE;
    endcase
    // timers; a set here wins over a clear made by the launch above
    if (!i_broadcast_enable)
    begin
      next_chg_sec = RST_BYTE;
      next_alm_sec = RST_BYTE;
      next_alm_run = 1'b0;
      next_pend_v = 1'b0; // RULE3
      next_pend_i = 1'b0;
      next_pend_a = 1'b0;
    end
    else
    begin
      if (sec_tick)
      begin
        if (chg_sec + 8'h01 >= period)
        begin
          next_chg_sec = RST_BYTE;
          next_pend_v = 1'b1;
          next_pend_i = 1'b1;
        end
        else
          next_chg_sec = chg_sec + 8'h01;
      end
      if (!alarm_any)
      begin
        next_alm_run = 1'b0;
        next_alm_sec = RST_BYTE;
        next_pend_a = 1'b0; // RULE6
      end
      else if (!alm_run)
      begin
        next_alm_run = 1'b1;
        next_alm_sec = RST_BYTE;
        next_pend_a = 1'b1;
      end
      else if (sec_tick)
      begin
        if (alm_sec + 8'h01 >= ALARM_PERIOD_S)
        begin
          next_alm_sec = RST_BYTE;
          next_pend_a = 1'b1; // RULE5
        end
        else
          next_alm_sec = alm_sec + 8'h01;
      end
    end
  end

  // registers
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      state <= S_IDLE;
      sec_cnt <= 28'h0;
      chg_sec <= RST_BYTE;
      alm_sec <= RST_BYTE;
      pend_v <= 1'b0;
      pend_i <= 1'b0;
      pend_a <= 1'b0;
      alm_run <= 1'b0;
      req <= 1'b0;
      pec <= 1'b0;
      cur_i2c <= 1'b0;
      busy <= 1'b0;
      lost <= 1'b0;
      nack <= 1'b0;
      kind <= K_VOLT;
      frame <= '0;
    end
    else
    begin
      state <= next_state;
      sec_cnt <= next_sec_cnt;
      chg_sec <= next_chg_sec;
      alm_sec <= next_alm_sec;
      pend_v <= next_pend_v;
      pend_i <= next_pend_i;
      pend_a <= next_pend_a;
      alm_run <= next_alm_run;
      req <= next_req;
      pec <= next_pec;
      cur_i2c <= next_cur_i2c;
      busy <= next_busy;
      lost <= next_lost;
      nack <= next_nack;
      kind <= next_kind;
      frame <= next_frame;
    end
  end

  // carrier and status
  assign lnk.req_tgl = req;
  assign lnk.frame = frame;
  assign lnk.pec_en = pec;
  assign o_busy = busy;
  assign o_last_lost = lost;
  assign o_last_nack = nack;
  assign o_alarm_active = alm_run;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  sequence s_launch;
    $rose(state == S_WAIT);
  endsequence
  sequence s_chg_launch;
    s_launch ##0 (kind != K_ALARM);
  endsequence

  a_broadcast_enable_gate_off: assert property (!i_broadcast_enable |=> !(pend_v || pend_i || pend_a)) // RULE3
    else $error("pending broadcast while broadcasts disabled");
  a_alarm_stop: assert property (!alarm_any |=> !pend_a && !alm_run) // RULE6
    else $error("alarm broadcast still pending after flags cleared");
  a_alarm_first: assert property (i_broadcast_enable && alarm_any && !alm_run |=> pend_a) // RULE5
    else $error("alarm broadcast not queued on first flag");
  a_smb_chg_addr: assert property (s_chg_launch ##0 !cur_i2c |-> frame[0] == CHG_ADDR_SMB) // RULE4
    else $error("wrong charger address in bus mode");
  a_smb_cmd_code: assert property (s_chg_launch ##0 !cur_i2c |->
    frame[1] == ((kind == K_VOLT) ? CMD_VOLT : CMD_CURR)) // RULE14
    else $error("wrong command code in bus mode");
  a_i2c_target: assert property (s_chg_launch ##0 cur_i2c |-> frame[1] ==
    ((kind == K_VOLT) ? $past(i_cfg_voltage_reg) : $past(i_cfg_current_reg))) // RULE8
    else $error("wrong target register in i2c mode");
  a_i2c_addr: assert property (s_chg_launch ##0 cur_i2c |->
    frame[0] == ($past(i_cfg_charger_addr) & WR_MASK)) // RULE7
    else $error("wrong charger address in i2c mode");
  a_low_byte_first: assert property (s_launch ##0 (kind == K_VOLT) |->
    frame[2] == $past(i_charge_voltage[7:0]) && frame[3] == $past(i_charge_voltage[15:8])) // RULE11
    else $error("voltage bytes out of order");
  a_i2c_no_pec: assert property (s_launch ##0 cur_i2c |-> !pec) // RULE13
    else $error("check byte requested in i2c mode");
  a_host_pec: assert property (s_launch ##0 (kind == K_ALARM) && !cur_i2c |->
    pec == $past(i_host_pec_enable)) // RULE1
    else $error("host check byte does not follow its enable");
  a_chg_pec: assert property (s_chg_launch ##0 !cur_i2c |-> pec == $past(i_charger_pec_enable)) // RULE2
    else $error("charger check byte does not follow its enable");
  a_pec_off: assert property (s_launch ##0 !$past(i_host_pec_enable) &&
    !$past(i_charger_pec_enable) |-> !pec) // RULE12
    else $error("check byte requested with both enables low");
  a_frame_hold: assert property (state == S_WAIT && $past(state == S_WAIT) |-> $stable(frame)) // RULE9
    else $error("frame changed while in flight");

endmodule // cbm_charge_broadcast_master
`default_nettype wire

// >>> test/cbm_charger_model.sv
// Purpose: charger on the bus, acks every byte, logs frames
// Assumes: lines pulled up, master drives open drain
// Notes: frames land in rx, their byte counts in len
`timescale 1ns/1ps
`default_nettype none
module cbm_charger_model
(
  // bus wire levels
  input wire logic i_scl,
  input wire logic i_sda,
  // ack pull on data line
  output logic o_ack_oe
);
  logic [7:0] rx[$];
  int len[$];
  logic [7:0] sh;
  int nb;
  int nbyte;
  initial
  begin
    o_ack_oe = 1'b0;
    nb = 0;
    nbyte = 0;
  end
  // start: fresh frame
  always @(negedge i_sda)
    if (i_scl === 1'b1)
    begin
      nb = 0;
      nbyte = 0;
    end
  // stop: close frame, its byte count logged in len
  always @(posedge i_sda)
    if (i_scl === 1'b1 && nbyte > 0)
    begin
      len.push_back(nbyte);
      nbyte = 0;
    end
  // msb first
  always @(posedge i_scl)
    if (nb < 8)
    begin
      sh = {sh[6:0], i_sda};
      nb++;
    end
  // ack driven across the ninth clock only, then released
  always @(negedge i_scl)
    if (nb == 8)
    begin
      rx.push_back(sh);
      nbyte++;
      o_ack_oe = 1'b1;
      nb = 9;
    end
    else if (nb == 9)
    begin
      o_ack_oe = 1'b0;
      nb = 0;
    end
endmodule // cbm_charger_model
`default_nettype wire

// >>> test/test_charge_broadcast_master.sv
// Purpose: self-checking bench for the broadcast master
// Assumes: one second shortened to 1000 system cycles, bus quarter to 4 link cycles
// Notes: each frame takes roughly five to six thousand cycles
`timescale 1ns/1ps
`default_nettype none
module test_charge_broadcast_master;
  import cbm_pkg::*;
  logic clk = 1'b0, lclk = 1'b0, rst = 1'b1, en = 1'b0, host_pec_enable = 1'b0, charger_pec_enable = 1'b0, i2c = 1'b0;
  logic [7:0] ca = 8'h00, vr = 8'h00, cr = 8'h00, pc = 8'h01;
  logic [15:0] v = 16'h0, c = 16'h0, aw = 16'h0;
  logic [5:0] fl = 6'h0;
  logic soe, doe, aoe, busy, alrm, nack, lost, poc, pod;
  wire scl_w;
  wire sda_w;
  int num_errors = 0;
  int comparisons = 0;
  assign scl_w = ~soe;
  assign sda_w = ~(doe | aoe);
  // link clock offset by 7 ns; every other one of its rising edges lines up with a system clock rising edge
  initial
  begin
    #7;
    forever #15 lclk = ~lclk;
  end
  initial
    forever #2 clk = ~clk;
  cbm_charge_broadcast_master #(.P_SEC_CYCLES(1000), .P_QTR_CYCLES(4))
    i_cbm_charge_broadcast_master (
    .i_clk_sys(clk), .i_rst(rst), .i_clk_link(lclk), .i_broadcast_enable(en),
    .i_host_pec_enable(host_pec_enable), .i_charger_pec_enable(charger_pec_enable), .i_i2c_mode(i2c),
    .i_cfg_charger_addr(ca), .i_cfg_voltage_reg(vr), .i_cfg_current_reg(cr),
    .i_cfg_pacing_s(pc), .i_charge_voltage(v), .i_charge_current(c), .i_alarm_word(aw),
    .i_overcharge_alarm_flag(fl[0]), .i_terminate_charge_alarm_flag(fl[1]),
    .i_overtemp_alarm_flag(fl[2]), .i_terminate_discharge_alarm_flag(fl[3]),
    .i_remaining_capacity_alarm_flag(fl[4]), .i_remaining_time_alarm_flag(fl[5]),
    .i_bus_clock_line(scl_w), .i_bus_data_line(sda_w), .o_bus_clock_line_out(poc),
    .o_bus_clock_line_oe(soe), .o_bus_data_line_out(pod), .o_bus_data_line_oe(doe),
    .o_busy(busy), .o_last_lost(lost), .o_last_nack(nack), .o_alarm_active(alrm));
  cbm_charger_model i_cbm_charger_model (.i_scl(scl_w), .i_sda(sda_w), .o_ack_oe(aoe));
  task automatic end_sim();
    if (num_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // reference frame built from integers, check byte crc-8
  task automatic expect_frame(input logic [7:0] a, input logic [7:0] k, input logic [15:0] d,
                              input logic pec);
    logic [7:0] q[$];
    logic [7:0] s;
    int n;
    q = '{a, k, d[7:0], d[15:8]};
    s = 8'h00;
    foreach (q[i])
    begin
      s = s ^ q[i];
      repeat (8) s = s[7] ? ((s << 1) ^ PEC_POLY) : (s << 1);
    end
    if (pec)
      q.push_back(s);
    n = 0;
    while (i_cbm_charger_model.len.size() == 0 && n < 20000)
    begin
      @(posedge clk);
      n++;
    end
    check(16'(n < 20000), 16'h1);
    if (n >= 20000)
      end_sim();
    check(16'(i_cbm_charger_model.len.pop_front()), 16'(q.size()));
    foreach (q[i])
      check({8'h00, i_cbm_charger_model.rx.pop_front()}, {8'h00, q[i]});
    // status settles only once completion has crossed back
    while (busy !== 1'b0)
      @(posedge clk);
    check({13'h0, nack, lost, poc | pod}, 16'h0);
  endtask
  task automatic quiet();
    int n;
    n = 0;
    en <= 1'b0;
    // a launch at this very edge shows busy only later
    repeat (2) @(posedge clk);
    while (busy !== 1'b0 && n < 300000)
    begin
      @(posedge clk);
      n++;
    end
    i_cbm_charger_model.len.delete();
    i_cbm_charger_model.rx.delete();
  endtask
  // bound covers about six frames plus the idle waits
  initial
  begin
    repeat (100000) @(posedge clk);
    num_errors++;
    end_sim();
  end
  initial
  begin
    void'($urandom(32'ha26b33a3));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    v <= 16'($urandom);
    c <= 16'($urandom);
    aw <= 16'($urandom);
    fl <= 6'h1 << ($urandom % 6);
    {en, host_pec_enable, charger_pec_enable} <= 3'b111;
    @(posedge clk);
    while (busy !== 1'b1)
      @(posedge clk);
    fl <= 6'h0;
    expect_frame(HOST_ADDR, CMD_ALARM, aw, 1'b1);
    check({15'h0, alrm}, 16'h0);
    expect_frame(CHG_ADDR_SMB, CMD_VOLT, v, 1'b1);
    // current frame has already latched its check enable here
    {host_pec_enable, charger_pec_enable} <= 2'b00;
    expect_frame(CHG_ADDR_SMB, CMD_CURR, c, 1'b1);
    expect_frame(CHG_ADDR_SMB, CMD_VOLT, v, 1'b0);
    quiet();
    ca <= 8'($urandom) & WR_MASK;
    // pacing longer than a frame keeps current from starving
    pc <= 8'h06 + 8'($urandom % 5);
    charger_pec_enable <= 1'b1;
    vr <= 8'($urandom);
    cr <= 8'($urandom);
    i2c <= 1'b1;
    @(posedge clk);
    en <= 1'b1;
    expect_frame(ca, vr, v, 1'b0);
    expect_frame(ca, cr, c, 1'b0);
    quiet();
    // a raised flag must not wake anything while disabled
    fl <= 6'h1 << ($urandom % 6);
    repeat (5000) @(posedge clk);
    check(16'(i_cbm_charger_model.len.size()), 16'h0);
    check({15'h0, busy}, 16'h0);
    check({15'h0, alrm}, 16'h0);
    end_sim();
  end
endmodule // test_charge_broadcast_master
`default_nettype wire
